// *** tb/shac_agent_model.sv ***
`timescale 1ns/100ps

module shac_agent_model #(
  parameter int W = 8
) (
  input  wire logic         sclk,
  input  wire logic         ss_n,
  input  wire logic         mosi,
  input  wire logic [W-1:0] reply,
  output logic              miso,
  output logic      [W-1:0] got
);
  logic [W-1:0] shreg;

  initial miso = 1'b0;
  initial got = '0;
  always @(negedge ss_n) begin
    shreg = reply;
    miso = reply[W-1];
  end
  always @(posedge sclk) if (!ss_n) got = {got[W-2:0], mosi};
  always @(negedge sclk) if (!ss_n) begin
    shreg = shreg << 1;
    miso = shreg[W-1];
  end
  // no pull on the line, so show the inverse, not a held value
  always @(posedge ss_n) miso = ~miso;
endmodule : shac_agent_model

// *** tb/shac_core_checker.sv ***
`timescale 1ns/100ps

module shac_core_checker #(
  parameter int WIDTH   = 8,
  parameter int NUM_SEL = 32
) (
  input wire logic               mclk,
  input wire logic               reset_n,
  input wire logic [WIDTH-1:0]   rx_data,
  input wire logic               rx_full,
  input wire logic               rx_overrun,
  input wire logic               tx_ready,
  input wire logic               busy,
  input wire logic               irq,
  input wire logic               sclk_out,
  input wire logic               mosi_out,
  input wire logic [NUM_SEL-1:0] ss_n_out,
  input wire logic [NUM_SEL-1:0] select_mask
);
  // ********************************************************************
  // link timing, written for a half period of 3 mclk
  // ********************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_sel_idle_high: assert property (!(&ss_n_out) |-> busy || $fell(&ss_n_out))
    else $error("select low while idle");
  a_sel_mask: assert property (!(&ss_n_out) |-> ss_n_out == ~select_mask)
    else $error("select does not follow mask");
  a_sclk_idle: assert property (&ss_n_out |-> !sclk_out)
    else $error("sclk toggles without select");
  a_sclk_high_half: assert property ($rose(sclk_out) |-> sclk_out[*3] ##1 !sclk_out)
    else $error("sclk high phase wrong");
  a_sclk_low_half: assert property ($fell(sclk_out) |-> !sclk_out[*3])
    else $error("sclk low phase short");
  a_mosi_steady: assert property (sclk_out && $past(sclk_out) |-> $stable(mosi_out))
    else $error("mosi moved while sclk high");
  a_sel_gap: assert property ($rose(&ss_n_out) |-> (&ss_n_out)[*3])
    else $error("select gap short");
  a_irq_pulse: assert property (irq |-> rx_full && !$past(irq))
    else $error("irq without completion");
  a_rx_hold: assert property (!$stable(rx_data) |-> rx_full)
    else $error("rx_data moved without completion");
  a_ovr_cause: assert property ($rose(rx_overrun) |-> $past(rx_full))
    else $error("overrun without full holding");
  a_word_bound: assert property ($rose(busy) |-> ##[1:80] !busy)
    else $error("word never ends");

  c_irq: cover property (irq);
  c_ovr: cover property ($rose(rx_overrun));
  c_full: cover property (!tx_ready);
endmodule : shac_core_checker

bind shac_core shac_core_checker #(.WIDTH(WIDTH), .NUM_SEL(NUM_SEL)) shac_core_checker_inst (
  .mclk(mclk), .reset_n(reset_n), .rx_data(rx_data), .rx_full(rx_full),
  .rx_overrun(rx_overrun), .tx_ready(tx_ready), .busy(busy), .irq(irq),
  .sclk_out(sclk_out), .mosi_out(mosi_out), .ss_n_out(ss_n_out),
  .select_mask(select_mask));

// *** tb/tb_top.sv ***
`timescale 1ns/100ps

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb_top;
  logic        mclk, reset_n, tx_valid, rx_read, ovr_clr, irq_en, miso;
  logic        tx_ready, rx_full, rx_ovr, tx_idle, busy, irq, sclk, mosi;
  logic [7:0]  tx_data, reply, rx_data, got;
  logic [31:0] mask, ss_n;
  logic        h_miso, a_full, a_ovr, a_busy, a_miso;
  logic [7:0]  a_rx;
  int          errors, n_tests, irqs, words, acc, refused;

  shac_core #(.HALF_DIV(3)) shac_core_inst (
    .mclk(mclk), .reset_n(reset_n), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_full(rx_full), .rx_read(rx_read),
    .rx_overrun(rx_ovr), .overrun_clear(ovr_clr), .tx_idle(tx_idle), .busy(busy),
    .irq_enable(irq_en), .select_mask(mask), .irq(irq), .sclk_out(sclk),
    .mosi_out(mosi), .ss_n_out(ss_n), .miso_in(miso), .sclk_in(1'b0),
    .ss_n_in(1'b1), .mosi_in(1'b0), .miso_out(h_miso));
  shac_agent_model shac_agent_model_inst (.sclk(sclk), .ss_n(ss_n[0]), .mosi(mosi),
    .reply(reply), .miso(miso), .got(got));
  // agent build listens on select 31 of the host build
  shac_core #(.HOST_MODE(1'b0)) shac_core_agent_inst (
    .mclk(mclk), .reset_n(reset_n), .tx_data(reply), .tx_valid(1'b0),
    .tx_ready(), .rx_data(a_rx), .rx_full(a_full), .rx_read(1'b0),
    .rx_overrun(a_ovr), .overrun_clear(1'b0), .tx_idle(), .busy(a_busy),
    .irq_enable(irq_en), .select_mask(mask), .irq(), .sclk_out(), .mosi_out(),
    .ss_n_out(), .miso_in(1'b0), .sclk_in(sclk), .ss_n_in(ss_n[31]),
    .mosi_in(mosi), .miso_out(a_miso));

  // ********************************************************************
  // clock, event counters, watchdog
  // ********************************************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) if (irq === 1'b1) irqs++;
  always @(negedge ss_n[0]) words++;
  initial begin
    #2_000_000;
    errors++;
    final_report();
  end

  // ********************************************************************
  // access tasks, all entered 10 ns after a rising edge
  // ********************************************************************
  task automatic push(input logic [7:0] w);
    tx_data = w;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) @(posedge mclk) #10;
    @(posedge mclk) #10;
    tx_valid = 1'b0;
    @(posedge mclk) #10;
  endtask : push

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge mclk) #10;
    s = 1'b0;
    @(posedge mclk) #10;
  endtask : pulse

  task automatic wait_done;
    int i;
    repeat (4) @(posedge mclk);
    #10;
    for (i = 0; i < 3000 && (tx_idle !== 1'b1 || busy !== 1'b0); i++) @(posedge mclk) #10;
    `CHK("drained", 1'b1, tx_idle & ~busy)
  endtask : wait_done

  task final_report;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // ********************************************************************
  // tests
  // ********************************************************************
  initial begin
    reset_n = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_read = 1'b0;
    ovr_clr = 1'b0;
    irq_en = 1'b1;
    reply = 8'h3C;
    mask = 32'h0000_0001;
    repeat (5) @(posedge mclk);
    #10 reset_n = 1'b1;
    `CHK("tx_ready", 1'b1, tx_ready)
    `CHK("ss_n", 32'hFFFF_FFFF, ss_n)
    `CHK("sclk", 1'b0, sclk)
    `CHK("rx_full", 1'b0, rx_full)
    $display("test reset done");

    push(8'hA5);
    wait_done();
    `CHK("rx_data", 8'h3C, rx_data)
    `CHK("agent got", 8'hA5, got)
    `CHK("rx_full", 1'b1, rx_full)
    `CHK("irqs", 1, irqs)
    pulse(rx_read);
    `CHK("rx_full", 1'b0, rx_full)
    $display("test single word done");

    // irq masked, two selects, holding never read
    irq_en = 1'b0;
    mask = 32'h8000_0001;
    reply = 8'hC3;
    push(8'h81);
    push(8'h7E);
    push(8'h5A);
    wait_done();
    `CHK("words", 4, words)
    `CHK("agent got", 8'h5A, got)
    `CHK("rx_data", 8'hC3, rx_data)
    `CHK("overrun", 1'b1, rx_ovr)
    `CHK("irqs", 1, irqs)
    `CHK("agent rx", 8'h5A, a_rx)
    `CHK("agent full", 1'b1, a_full)
    `CHK("agent overrun", 1'b1, a_ovr)
    `CHK("agent busy", 1'b0, a_busy)
    `CHK("agent miso", 1'b0, a_miso)
    `CHK("host miso", 1'b0, h_miso)
    pulse(ovr_clr);
    pulse(rx_read);
    `CHK("overrun", 1'b0, rx_ovr)
    $display("test back to back done");

    // push 20 words into the fifo, past the point where it refuses, link drains it meanwhile
    irq_en = 1'b1;
    mask = 32'h0000_0001;
    reply = 8'h96;
    acc = 0;
    refused = 0;
    tx_valid = 1'b1;
    while (acc < 20) begin
      tx_data = 8'(acc + 1);
      if (tx_ready === 1'b1) acc++;
      else refused++;
      @(posedge mclk) #10;
    end
    tx_valid = 1'b0;
    wait_done();
    `CHK("refused", 1'b1, refused > 0)
    `CHK("words", 24, words)
    `CHK("agent got", 8'h14, got)
    `CHK("rx_data", 8'h96, rx_data)
    `CHK("irqs", 21, irqs)
    $display("test fifo fill done");
    final_report();
  end
endmodule : tb_top

// *** verilog/shac_core.sv ***
`timescale 1ns/100ps

module shac_core #(
  parameter bit HOST_MODE  = 1'b1,
  parameter int WIDTH      = shac_pkg::SHAC_WIDTH,
  parameter int NUM_SEL    = shac_pkg::SHAC_NUM_SEL,
  parameter bit LSB_FIRST  = 1'b0,
  parameter int HALF_DIV   = shac_pkg::SHAC_HALF_DIV,
  parameter int FIFO_DEPTH = shac_pkg::SHAC_FIFO_DEPTH
) (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic [WIDTH-1:0]   tx_data,
  input  wire logic               tx_valid,
  output logic                    tx_ready,
  output logic      [WIDTH-1:0]   rx_data,
  output logic                    rx_full,
  input  wire logic               rx_read,
  output logic                    rx_overrun,
  input  wire logic               overrun_clear,
  output logic                    tx_idle,
  output logic                    busy,
  input  wire logic               irq_enable,
  input  wire logic [NUM_SEL-1:0] select_mask,
  output logic                    irq,
  output logic                    sclk_out,
  output logic                    mosi_out,
  output logic      [NUM_SEL-1:0] ss_n_out,
  input  wire logic               miso_in,
  input  wire logic               sclk_in,
  input  wire logic               ss_n_in,
  input  wire logic               mosi_in,
  output logic                    miso_out
);

  localparam int CB = shac_pkg::SHAC_CNT_BITS;
  localparam int DB = shac_pkg::SHAC_DIV_BITS;
  localparam logic [CB-1:0] CNT_LAST = CB'(WIDTH - 1);
  localparam logic [CB-1:0] CNT_FULL = CB'(WIDTH);
  localparam logic [DB-1:0] DIV_LAST = DB'(HALF_DIV - 1);

  // ********************************************************************
  // bit order helpers
  // ********************************************************************
  // lsb first shifts right and enters at the top; msb first the reverse
  function automatic logic [WIDTH-1:0] shift_in(input logic [WIDTH-1:0] v,
                                                input logic             b);
    logic [WIDTH-1:0] r;
    r = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (LSB_FIRST) begin
        r[i] = (i == WIDTH - 1) ? b : v[i+1];
      end else begin
        r[i] = (i == 0) ? b : v[i-1];
      end
    end
    return r;
  endfunction : shift_in

  function automatic logic out_bit(input logic [WIDTH-1:0] v);
    return LSB_FIRST ? v[0] : v[WIDTH-1];
  endfunction : out_bit

  // ********************************************************************
  // signals
  // ********************************************************************
  logic [3:0]           sync1;
  logic [3:0]           sync2;
  logic                 sclk_prev;
  logic                 ss_prev;
  logic                 miso_s;
  logic                 sclk_s;
  logic                 ss_s;
  logic                 mosi_s;
  shac_pkg::shac_state_t state;
  logic [DB-1:0]        div_cnt;
  logic                 tick;
  logic [WIDTH-1:0]     fifo_data;
  logic                 fifo_valid;
  logic                 fifo_take;
  logic [WIDTH-1:0]     hold_data;
  logic                 hold_valid;
  logic [WIDTH-1:0]     tx_shift;
  logic [WIDTH-1:0]     rx_shift;
  logic [CB-1:0]        bit_cnt;
  logic                 load_evt;
  logic                 sample_evt;
  logic                 shift_evt;
  logic                 sample_bit;
  logic                 done_evt;

  // ********************************************************************
  // pin synchronisers
  // ********************************************************************
  // only sync2 feeds logic; the edge detectors look at sync2 and its copy
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // sclk idles low, so a reset value of 1 would fake a rising edge
      sync1     <= 4'h4;
      sync2     <= 4'h4;
      sclk_prev <= 1'b0;
      ss_prev   <= 1'b1;
    end else begin
      sync1     <= {mosi_in, ss_n_in, sclk_in, miso_in};
      sync2     <= sync1;
      sclk_prev <= sync2[1];
      ss_prev   <= sync2[2];
    end
  end

  assign miso_s = sync2[0];
  assign sclk_s = sync2[1];
  assign ss_s   = sync2[2];
  assign mosi_s = sync2[3];

  // ********************************************************************
  // transmit buffering
  // ********************************************************************
  // holding slot frees on the load, so a new word lands mid-shift
  assign fifo_take = fifo_valid & (~hold_valid | load_evt);

  shac_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_data  <= '0;
      hold_valid <= 1'b0;
    end else if (fifo_take) begin
      hold_data  <= fifo_data;
      hold_valid <= 1'b1;
    end else if (load_evt) begin
      hold_valid <= 1'b0;
    end
  end

  // ********************************************************************
  // host sequencer and clock divider
  // ********************************************************************
  assign tick = (div_cnt == DIV_LAST);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= shac_pkg::SHAC_IDLE;
      div_cnt  <= '0;
      sclk_out <= shac_pkg::SHAC_SCLK_IDLE;
      ss_n_out <= {NUM_SEL{shac_pkg::SHAC_SEL_OFF}};
    end else if (HOST_MODE) begin
      div_cnt <= (tick || state == shac_pkg::SHAC_IDLE) ? '0 : div_cnt + DB'(1);
      case (state)
        shac_pkg::SHAC_IDLE: begin
          if (hold_valid) begin
            ss_n_out <= ~select_mask;
            state    <= shac_pkg::SHAC_LEAD;
          end
        end
        shac_pkg::SHAC_LEAD: begin
          if (tick) begin
            state <= shac_pkg::SHAC_SHIFT;
          end
        end
        shac_pkg::SHAC_SHIFT: begin
          if (tick) begin
            sclk_out <= ~sclk_out;
            if (sclk_out && bit_cnt == CNT_FULL) begin
              state <= shac_pkg::SHAC_LAG;
            end
          end
        end
        shac_pkg::SHAC_LAG: begin
          if (tick) begin
            ss_n_out <= {NUM_SEL{shac_pkg::SHAC_SEL_OFF}};
            state    <= shac_pkg::SHAC_GAP;
          end
        end
        shac_pkg::SHAC_GAP: begin
          // select stays high a half period before the next word
          if (tick) begin
            state <= shac_pkg::SHAC_IDLE;
          end
        end
        default: begin
          state <= shac_pkg::SHAC_IDLE;
        end
      endcase
    end
  end

  // ********************************************************************
  // shift events
  // ********************************************************************
  always_comb begin
    load_evt   = 1'b0;
    sample_evt = 1'b0;
    shift_evt  = 1'b0;
    sample_bit = 1'b0;
    if (HOST_MODE) begin
      sample_bit = miso_s;
      load_evt   = (state == shac_pkg::SHAC_IDLE) & hold_valid;
      if (state == shac_pkg::SHAC_SHIFT && tick) begin
        sample_evt = ~sclk_out;
        shift_evt  = sclk_out & (bit_cnt != CNT_FULL);
      end
    end else begin
      sample_bit = mosi_s;
      load_evt   = ~ss_s & ss_prev;
      sample_evt = ~ss_s & sclk_s & ~sclk_prev;
      shift_evt  = ~ss_s & ~sclk_s & sclk_prev & (bit_cnt != CNT_FULL);
    end
  end

  assign done_evt = sample_evt & (bit_cnt == CNT_LAST);

  // ********************************************************************
  // shift registers
  // ********************************************************************
  // an agent selected with nothing queued repeats the last holding word
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift <= '0;
      rx_shift <= '0;
      bit_cnt  <= '0;
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
    end else begin
      if (load_evt) begin
        tx_shift <= hold_data;
        bit_cnt  <= '0;
      end else if (shift_evt) begin
        tx_shift <= shift_in(tx_shift, 1'b0);
      end
      if (sample_evt) begin
        rx_shift <= shift_in(rx_shift, sample_bit);
        bit_cnt  <= bit_cnt + CB'(1);
      end
      if (load_evt || shift_evt) begin
        if (HOST_MODE) begin
          mosi_out <= out_bit(load_evt ? hold_data : shift_in(tx_shift, 1'b0));
        end else begin
          miso_out <= out_bit(load_evt ? hold_data : shift_in(tx_shift, 1'b0));
        end
      end
    end
  end

  // ********************************************************************
  // receive holding and status
  // ********************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_data <= '0;
    end else if (done_evt) begin
      rx_data <= shift_in(rx_shift, sample_bit);
    end
  end

  // new data beats a read in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_full    <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      if (done_evt) begin
        rx_full <= 1'b1;
      end else if (rx_read) begin
        rx_full <= 1'b0;
      end
      if (done_evt && rx_full && !rx_read) begin
        rx_overrun <= 1'b1;
      end else if (overrun_clear) begin
        rx_overrun <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy    <= 1'b0;
      tx_idle <= 1'b1;
      irq     <= 1'b0;
    end else begin
      busy    <= HOST_MODE ? (state != shac_pkg::SHAC_IDLE) : ~ss_s;
      tx_idle <= ~hold_valid & ~fifo_valid;
      irq     <= irq_enable & done_evt;
    end
  end

endmodule : shac_core

// *** verilog/shac_fifo.sv ***
`timescale 1ns/100ps

module shac_fifo #(
  parameter int WIDTH = shac_pkg::SHAC_WIDTH,
  parameter int DEPTH = shac_pkg::SHAC_FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign push = in_valid & in_ready;
  // refill the output register whenever it is empty or being drained
  assign pop  = (count != '0) & (~out_valid | out_ready);

  always_comb begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + CW'(1);
    end else if (pop & ~push) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PW'(1);
      end
      count    <= next_count;
      in_ready <= (next_count != CNT_FULL);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end else if (pop) begin
      out_data  <= mem[rd_ptr];
      out_valid <= 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : shac_fifo

// *** verilog/shac_pkg.sv ***
package shac_pkg;

  // ********************************************************************
  // word and select sizing
  // ********************************************************************
  localparam int SHAC_WIDTH       = 8;
  localparam int SHAC_WIDTH_MIN   = 1;
  localparam int SHAC_WIDTH_MAX   = 32;
  localparam int SHAC_NUM_SEL     = 32;
  localparam int SHAC_FIFO_DEPTH  = 16;
  localparam int SHAC_CNT_BITS    = 6;

  // ********************************************************************
  // serial clock derivation
  // ********************************************************************
  localparam int SHAC_SYS_CLK_HZ  = 10_000_000;
  localparam int SHAC_SCLK_TGT_HZ = 1_000_000;
  // round the half period up so sclk never exceeds the target rate
  localparam int SHAC_HALF_DIV    = (SHAC_SYS_CLK_HZ + 2 * SHAC_SCLK_TGT_HZ - 1)
                                    / (2 * SHAC_SCLK_TGT_HZ);
  localparam int SHAC_CLK_DIV     = 2 * SHAC_HALF_DIV;
  localparam int SHAC_DIV_BITS    = 16;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic SHAC_SEL_OFF   = 1'b1;
  localparam logic SHAC_SCLK_IDLE = 1'b0;

  // ********************************************************************
  // host sequencer
  // ********************************************************************
  typedef enum logic [2:0] {
    SHAC_IDLE  = 3'h0,
    SHAC_LEAD  = 3'h1,
    SHAC_SHIFT = 3'h2,
    SHAC_LAG   = 3'h3,
    SHAC_GAP   = 3'h4
  } shac_state_t;

endpackage : shac_pkg
